//--- rtl/dmrs_top.sv
`timescale 1ns/1ns
module dmrs_top (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] TRANSFER_REQUEST_LINE,
  input wire logic TIMER_MAX_COUNT,
  input wire logic NMI_EVENT,
  input wire logic INTERRUPT_RETURN_INSTRUCTION,
  output logic BUS_OWN,
  output logic CYC_START,
  output logic CYC_FETCH,
  output logic CYC_DEPOSIT,
  output logic CYC_CHAN,
  output logic TRANSFER_HALT_FLAG
);
  logic [1:0] rq_meta;
  logic [1:0] rq_sync;
  localparam int CTL_W_LOCAL = dmrs_pkg::CTL_W;
  logic [CTL_W_LOCAL-1:0] ctrl [2];
  logic [15:0] count [2];
  logic tmr_latch;
  logic halt;
  dmrs_pkg::dmrs_state_t state;
  logic [2:0] cnt;
  logic chan;
  logic last_chan;
  logic pend;
  logic pend_ch;
  logic pend_tmr;
  logic cur_tmr;

  dmrs_pkg::dmrs_state_t next_state;
  logic [2:0] next_cnt;
  logic next_chan;
  logic next_pend;
  logic next_pend_ch;
  logic next_pend_tmr;
  logic next_cur_tmr;
  logic next_start_pulse;

  // Bus access decode.
  wire acc = PSEL & PENABLE;
  wire wr_take = acc & PREADY & PWRITE;
  wire w_ctrl0 = wr_take & (PADDR == dmrs_pkg::ADDR_CTRL0);
  wire w_ctrl1 = wr_take & (PADDR == dmrs_pkg::ADDR_CTRL1);
  wire w_cnt0 = wr_take & (PADDR == dmrs_pkg::ADDR_CNT0);
  wire w_cnt1 = wr_take & (PADDR == dmrs_pkg::ADDR_CNT1);
  wire w_halt = wr_take & (PADDR == dmrs_pkg::ADDR_HALT);
  wire mapped = (PADDR == dmrs_pkg::ADDR_CTRL0) || (PADDR == dmrs_pkg::ADDR_CTRL1) ||
                (PADDR == dmrs_pkg::ADDR_CNT0) || (PADDR == dmrs_pkg::ADDR_CNT1) ||
                (PADDR == dmrs_pkg::ADDR_HALT) || (PADDR == dmrs_pkg::ADDR_STAT);
  logic [31:0] rd_val;
  always_comb begin
    if (PADDR == dmrs_pkg::ADDR_CTRL0) begin
      rd_val = {24'h000000, ctrl[0]};
    end else if (PADDR == dmrs_pkg::ADDR_CTRL1) begin
      rd_val = {24'h000000, ctrl[1]};
    end else if (PADDR == dmrs_pkg::ADDR_CNT0) begin
      rd_val = {16'h0000, count[0]};
    end else if (PADDR == dmrs_pkg::ADDR_CNT1) begin
      rd_val = {16'h0000, count[1]};
    end else if (PADDR == dmrs_pkg::ADDR_HALT) begin
      rd_val = {31'h00000000, halt};
    end else if (PADDR == dmrs_pkg::ADDR_STAT) begin
      rd_val = {28'h0000000, chan, BUS_OWN, halt, tmr_latch};
    end else begin
      rd_val = 32'h00000000;
    end
  end

  // Per-channel request view.
  logic [1:0] start;
  logic [1:0] tsel;
  logic [1:0] prio;
  logic [1:0] uns;
  logic [1:0] dst;
  logic [1:0] ext;
  logic [1:0] req;
  logic [1:0] from_tmr;
  logic [2:0] cyc_len [2];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      start[i] = ctrl[i][dmrs_pkg::CTL_START];
      tsel[i] = ctrl[i][dmrs_pkg::CTL_TSEL];
      prio[i] = ctrl[i][dmrs_pkg::CTL_PRIO];
      uns[i] = ctrl[i][dmrs_pkg::CTL_SYNC_LO +: 2] == dmrs_pkg::SYNC_UNS;
      dst[i] = ctrl[i][dmrs_pkg::CTL_SYNC_LO +: 2] == dmrs_pkg::SYNC_DST;
      ext[i] = dst[i] | (ctrl[i][dmrs_pkg::CTL_SYNC_LO +: 2] == dmrs_pkg::SYNC_SRC);
      from_tmr[i] = tsel[i] & tmr_latch;
      req[i] = start[i] & (tsel[i] ? tmr_latch : (uns[i] | (ext[i] & rq_sync[i])));
      // Wait states stretch each bus cycle beyond the four-clock minimum.
      cyc_len[i] = dmrs_pkg::BUS_MIN - 3'h1 + {1'b0, ctrl[i][dmrs_pkg::CTL_WS_LO +: 2]};
    end
  end

  // Arbitration: higher priority wins, equal priority alternates.
  wire both = req[0] & req[1];
  wire arb_ch = both ? ((prio[0] == prio[1]) ? ~last_chan : prio[1]) : req[1];
  wire arb_ok = (req[0] | req[1]) & ~halt;

  // Count update at the end of a deposit cycle.
  wire dep_end = (state == dmrs_pkg::ST_DEP) && (cnt == 3'h0);
  wire [15:0] cnt_dec = count[chan] - 16'h0001;
  wire stop_now = (cnt_dec == 16'h0000) & (ctrl[chan][dmrs_pkg::CTL_TCSTOP] | uns[chan]);
  wire pend_alive = pend & ~halt & ~(stop_now & (pend_ch == chan));
  // Resampling point: deposit start for source and self-paced modes, one clock
  // before the deposit end for destination mode.
  wire enter_dep = (state == dmrs_pkg::ST_FETCH) && (cnt == 3'h0);
  wire dst_pt = (state == dmrs_pkg::ST_DEP) && (cnt == dmrs_pkg::DST_SAMPLE) && dst[chan];
  wire samp = (enter_dep & ~dst[chan]) | dst_pt;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_chan = chan;
    next_pend = pend;
    next_pend_ch = pend_ch;
    next_pend_tmr = pend_tmr;
    next_cur_tmr = cur_tmr;
    next_start_pulse = 1'b0;
    if (samp) begin
      next_pend = arb_ok;
      next_pend_ch = arb_ch;
      next_pend_tmr = from_tmr[arb_ch];
    end
    case (state)
      dmrs_pkg::ST_IDLE: begin
        if (arb_ok) begin
          next_state = dmrs_pkg::ST_LAT;
          next_cnt = dmrs_pkg::REQ_LEAD - 3'h2;
          next_chan = arb_ch;
          next_cur_tmr = from_tmr[arb_ch];
        end
      end
      dmrs_pkg::ST_LAT: begin
        if (cnt == 3'h0) begin
          next_state = dmrs_pkg::ST_FETCH;
          next_cnt = cyc_len[chan];
          next_start_pulse = 1'b1;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      dmrs_pkg::ST_FETCH: begin
        if (cnt == 3'h0) begin
          next_state = dmrs_pkg::ST_DEP;
          next_cnt = cyc_len[chan];
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      dmrs_pkg::ST_DEP: begin
        if (cnt != 3'h0) begin
          next_cnt = cnt - 3'h1;
        end else if (pend_alive && dst[chan]) begin
          next_state = dmrs_pkg::ST_GAP;
          next_cnt = dmrs_pkg::DST_GAP - 3'h1;
        end else if (pend_alive) begin
          next_state = dmrs_pkg::ST_FETCH;
          next_cnt = cyc_len[pend_ch];
          next_chan = pend_ch;
          next_cur_tmr = pend_tmr;
          next_start_pulse = 1'b1;
        end else if (dst[chan]) begin
          next_state = dmrs_pkg::ST_GAP;
          next_cnt = dmrs_pkg::DST_GAP - 3'h1;
          next_pend = 1'b0;
        end else begin
          next_state = dmrs_pkg::ST_IDLE;
        end
      end
      dmrs_pkg::ST_GAP: begin
        // The bus is free here so the CPU may slip a cycle in.
        if (cnt != 3'h0) begin
          next_cnt = cnt - 3'h1;
        end else if (pend & ~halt) begin
          next_state = dmrs_pkg::ST_FETCH;
          next_cnt = cyc_len[pend_ch];
          next_chan = pend_ch;
          next_cur_tmr = pend_tmr;
          next_start_pulse = 1'b1;
        end else begin
          next_state = dmrs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dmrs_pkg::ST_IDLE;
      end
    endcase
  end

  wire fetch_next = next_state == dmrs_pkg::ST_FETCH;
  wire dep_next = next_state == dmrs_pkg::ST_DEP;
  wire tmr_clear = (next_start_pulse & next_cur_tmr) | ~(tsel[0] | tsel[1]);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      rq_meta <= 2'h0;
      rq_sync <= 2'h0;
    end else begin
      rq_meta <= TRANSFER_REQUEST_LINE;
      rq_sync <= rq_meta;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state <= dmrs_pkg::ST_IDLE;
      cnt <= 3'h0;
      chan <= 1'b0;
      last_chan <= 1'b1;
      pend <= 1'b0;
      pend_ch <= 1'b0;
      pend_tmr <= 1'b0;
      cur_tmr <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      chan <= next_chan;
      pend <= next_pend;
      pend_ch <= next_pend_ch;
      pend_tmr <= next_pend_tmr;
      cur_tmr <= next_cur_tmr;
      if (next_start_pulse) begin
        last_chan <= next_chan;
      end
    end
  end

  // A new timeout in the clearing cycle wins, so no timeout is lost to a race.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      tmr_latch <= 1'b0;
    end else if (TIMER_MAX_COUNT & (tsel[0] | tsel[1])) begin
      tmr_latch <= 1'b1;
    end else if (tmr_clear) begin
      tmr_latch <= 1'b0;
    end
  end

  // The halt flag touches no channel register, so clearing it resumes exactly.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      halt <= 1'b0;
    end else if (NMI_EVENT | (w_halt & PWDATA[0])) begin
      halt <= 1'b1;
    end else if (INTERRUPT_RETURN_INSTRUCTION | w_halt) begin
      halt <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ctrl[0] <= dmrs_pkg::CTL_RESET;
      ctrl[1] <= dmrs_pkg::CTL_RESET;
      count[0] <= dmrs_pkg::CNT_RESET;
      count[1] <= dmrs_pkg::CNT_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? w_ctrl0 : w_ctrl1) begin
          ctrl[i] <= PWDATA[CTL_W_LOCAL-1:0];
        end else if (dep_end && (chan == i[0]) && stop_now) begin
          ctrl[i][dmrs_pkg::CTL_START] <= 1'b0;
        end
        if ((i == 0) ? w_cnt0 : w_cnt1) begin
          count[i] <= PWDATA[15:0];
        end else if (dep_end && (chan == i[0])) begin
          count[i] <= cnt_dec;
        end
      end
    end
  end

  // Cycle outputs; the peripheral is addressed by the cycle itself.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      BUS_OWN <= 1'b0;
      CYC_START <= 1'b0;
      CYC_FETCH <= 1'b0;
      CYC_DEPOSIT <= 1'b0;
      CYC_CHAN <= 1'b0;
      TRANSFER_HALT_FLAG <= 1'b0;
    end else begin
      BUS_OWN <= fetch_next | dep_next;
      CYC_START <= next_start_pulse;
      CYC_FETCH <= fetch_next;
      CYC_DEPOSIT <= dep_next;
      CYC_CHAN <= next_chan;
      TRANSFER_HALT_FLAG <= NMI_EVENT | (w_halt & PWDATA[0]) |
                            (halt & ~INTERRUPT_RETURN_INSTRUCTION & ~w_halt);
    end
  end

  // Bus slave answers one clock into the access phase.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= acc & ~PREADY;
      PSLVERR <= acc & ~PREADY & ~mapped;
      PRDATA <= (acc & ~PREADY & ~PWRITE) ? rd_val : 32'h00000000;
    end
  end
endmodule : dmrs_top

//--- rtl/dmrs_pkg.sv
package dmrs_pkg;
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CNT0 = 8'h08;
  localparam logic [7:0] ADDR_CNT1 = 8'h0c;
  localparam logic [7:0] ADDR_HALT = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // Control register fields.
  localparam int CTL_START = 0;
  localparam int CTL_SYNC_LO = 1;
  localparam int CTL_TSEL = 3;
  localparam int CTL_TCSTOP = 4;
  localparam int CTL_PRIO = 5;
  localparam int CTL_WS_LO = 6;
  localparam int CTL_W = 8;
  localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Synchronisation modes held in the two sync bits.
  localparam logic [1:0] SYNC_UNS = 2'h0;
  localparam logic [1:0] SYNC_SRC = 2'h1;
  localparam logic [1:0] SYNC_DST = 2'h2;
  // Timing in CPU clocks.
  localparam logic [2:0] REQ_LEAD = 3'h4;
  localparam logic [2:0] BUS_MIN = 3'h4;
  localparam logic [2:0] DST_GAP = 3'h2;
  localparam logic [2:0] DST_SAMPLE = 3'h1;
  typedef enum logic [2:0] {ST_IDLE, ST_LAT, ST_FETCH, ST_DEP, ST_GAP} dmrs_state_t;
endpackage : dmrs_pkg

//--- bench/dmrs_assertions.sv
`timescale 1ns/1ns
module dmrs_assertions (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic NMI_EVENT,
  input wire logic INTERRUPT_RETURN_INSTRUCTION,
  input wire logic BUS_OWN,
  input wire logic CYC_START,
  input wire logic CYC_FETCH,
  input wire logic CYC_DEPOSIT,
  input wire logic TRANSFER_HALT_FLAG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  a_start_fetch: assert property (CYC_START |-> $rose(CYC_FETCH) && BUS_OWN)
    else $error("start without new fetch");
  a_fetch_len: assert property ($rose(CYC_FETCH) |-> CYC_FETCH [*4])
    else $error("fetch too short");
  a_deposit_len: assert property ($rose(CYC_DEPOSIT) |-> CYC_DEPOSIT [*4])
    else $error("deposit too short");
  a_pair_whole: assert property ($fell(CYC_FETCH) |-> CYC_DEPOSIT && BUS_OWN)
    else $error("fetch not followed by deposit");
  a_bus_held: assert property (CYC_FETCH || CYC_DEPOSIT |-> BUS_OWN)
    else $error("cycle without bus");
  a_nmi_halt: assert property (NMI_EVENT |=> TRANSFER_HALT_FLAG)
    else $error("halt not set");
  a_interrupt_return_instruction_clear: assert property (INTERRUPT_RETURN_INSTRUCTION && !NMI_EVENT
    && !(PSEL && PWRITE) |=> !TRANSFER_HALT_FLAG)
    else $error("halt not cleared");
  a_halt_block: assert property (TRANSFER_HALT_FLAG [*8] |-> !CYC_START)
    else $error("transfer while halted");
  a_apb_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("apb answer late");
  a_err_map: assert property (PREADY && PADDR[1:0] == 2'h0
    |-> PSLVERR == (PADDR > dmrs_pkg::ADDR_STAT))
    else $error("apb error wrong");
  c_deposit: cover property ($fell(CYC_DEPOSIT));
  c_nmi: cover property (NMI_EVENT);
  c_err: cover property (PSLVERR);
endmodule : dmrs_assertions

//--- bench/dmrs_periph.sv
`timescale 1ns/1ns
module dmrs_periph (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] add,
  input wire logic late,
  input wire logic cyc_start,
  input wire logic cyc_chan,
  input wire logic cyc_deposit,
  output logic [1:0] req
);
  logic [3:0] pend [2];
  logic dep_q;
  logic ack;
  // A late device only sees its acknowledge when the deposit begins, so its
  // request falls too late unless wait states stretch the deposit.
  assign ack = late ? (cyc_deposit && !dep_q) : cyc_start;
  assign req[0] = pend[0] != 4'h0;
  assign req[1] = pend[1] != 4'h0;
  always_ff @(posedge clk) begin
    dep_q <= cyc_deposit;
    for (int c = 0; c < 2; c++) begin
      if (!rst_b)
        pend[c] <= 4'h0;
      else if (add[c])
        pend[c] <= pend[c] + 4'h1;
      else if (ack && cyc_chan == c[0] && pend[c] != 4'h0)
        pend[c] <= pend[c] - 4'h1;
    end
  end
endmodule : dmrs_periph

//--- bench/tb_dma_request_sync_control.sv
`timescale 1ns/1ns
module tb_dma_request_sync_control;
  localparam logic [7:0] C0 = dmrs_pkg::ADDR_CTRL0;
  localparam logic [7:0] C1 = dmrs_pkg::ADDR_CTRL1;
  localparam logic [7:0] N0 = dmrs_pkg::ADDR_CNT0;
  localparam logic [7:0] HL = dmrs_pkg::ADDR_HALT;
  localparam logic [7:0] ST = dmrs_pkg::ADDR_STAT;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic TIMER_MAX_COUNT = 1'b0;
  logic NMI_EVENT = 1'b0;
  logic INTERRUPT_RETURN_INSTRUCTION = 1'b0;
  logic [1:0] TRANSFER_REQUEST_LINE;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, BUS_OWN, CYC_START, CYC_FETCH, CYC_DEPOSIT, CYC_CHAN;
  logic TRANSFER_HALT_FLAG;
  logic [1:0] add = 2'h0;
  logic late = 1'b0;
  logic [31:0] r;
  logic e;
  logic last_chan;
  logic prev_own = 1'b0;
  int failures = 0;
  int cmp_count = 0;
  int starts [2] = '{0, 0};
  int same, rises, gap, idle, cycles, dep_run, dep_last;
  dmrs_top DUT (.*);
  dmrs_periph u_dev (.clk(CLK_SYS), .rst_b(RST_B), .add(add), .late(late),
    .cyc_start(CYC_START), .cyc_chan(CYC_CHAN), .cyc_deposit(CYC_DEPOSIT),
    .req(TRANSFER_REQUEST_LINE));
  initial begin
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  task automatic results();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // Idle gaps are measured here so that the bus release can be judged exactly.
  always @(posedge CLK_SYS) begin
    if (BUS_OWN === 1'b1 && prev_own === 1'b0) begin
      rises++;
      gap = idle;
    end
    idle = (BUS_OWN === 1'b1) ? 0 : idle + 1;
    prev_own = BUS_OWN;
    if (CYC_DEPOSIT === 1'b1) begin
      dep_run++;
    end else if (dep_run > 0) begin
      dep_last = dep_run;
      dep_run = 0;
    end
    if (CYC_START === 1'b1) begin
      starts[CYC_CHAN]++;
      if (CYC_CHAN === last_chan) same++;
      last_chan = CYC_CHAN;
    end
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, r);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : tick
  task automatic quiet();
    for (int q = 0; q < 20; q = (BUS_OWN === 1'b1) ? 0 : q + 1) @(posedge CLK_SYS);
  endtask : quiet
  task automatic fresh(input string nm);
    $display("test %s done", nm);
    starts = '{0, 0};
    same = 0;
    rises = 0;
    last_chan = 1'bx;
  endtask : fresh
  initial begin
    tick(12);
    RST_B <= 1'b1;
    tick(1);
    rd(C0, 32'h0);
    rd(HL, 32'h0);
    rd(8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    fresh("reset");
    wr(N0, 32'h3);
    wr(C0, 32'h01);
    quiet();
    chk("unsync count", 32'd3, starts[0]);
    chk("unsync grants", 32'd1, rises);
    rd(C0, 32'h0);
    fresh("unsync");
    wr(N0, 32'h10);
    wr(C0, 32'h09);
    wr(C1, 32'h09);
    TIMER_MAX_COUNT <= 1'b1;
    tick(2);
    TIMER_MAX_COUNT <= 1'b0;
    quiet();
    chk("timer count", 32'd1, starts[0] + starts[1]);
    TIMER_MAX_COUNT <= 1'b1;
    tick(1);
    TIMER_MAX_COUNT <= 1'b0;
    quiet();
    chk("timer again", 32'd2, starts[0] + starts[1]);
    wr(C1, 32'h0);
    wr(C0, 32'h08);
    TIMER_MAX_COUNT <= 1'b1;
    tick(1);
    TIMER_MAX_COUNT <= 1'b0;
    apb(1'b0, ST, 32'h0);
    chk("latch set", 32'h1, r & 32'h1);
    wr(C0, 32'h0);
    apb(1'b0, ST, 32'h0);
    chk("latch clear", 32'h0, r & 32'h1);
    fresh("timer");
    wr(N0, 32'h4);
    wr(dmrs_pkg::ADDR_CNT1, 32'h4);
    wr(C0, 32'h03);
    wr(C1, 32'h03);
    add <= 2'h3;
    tick(2);
    add <= 2'h0;
    quiet();
    chk("source total", 32'd4, starts[0] + starts[1]);
    chk("alternation", 32'd0, same);
    chk("source grants", 32'd1, rises);
    rd(N0, 32'h2);
    wr(C1, 32'h0);
    fresh("source");
    wr(N0, 32'h8);
    wr(C0, 32'h05);
    add <= 2'h1;
    tick(2);
    add <= 2'h0;
    quiet();
    chk("dest count", 32'd2, starts[0]);
    chk("dest grants", 32'd2, rises);
    chk("dest gap", 32'd2, gap);
    late <= 1'b1;
    add <= 2'h1;
    tick(1);
    add <= 2'h0;
    quiet();
    chk("late drop", 32'd4, starts[0]);
    wr(C0, 32'h45);
    add <= 2'h1;
    tick(1);
    add <= 2'h0;
    quiet();
    chk("wait drop", 32'd5, starts[0]);
    chk("wait deposit", 32'd5, dep_last);
    late <= 1'b0;
    fresh("dest");
    wr(HL, 32'h1);
    wr(N0, 32'h4);
    wr(C0, 32'h01);
    tick(30);
    chk("halted", 32'd0, starts[0]);
    wr(HL, 32'h0);
    for (int n = 0; n < 50 && CYC_START !== 1'b1; n++) @(posedge CLK_SYS);
    NMI_EVENT <= 1'b1;
    tick(1);
    NMI_EVENT <= 1'b0;
    quiet();
    chk("nmi stop", 32'd1, starts[0]);
    chk("halt flag", 32'h1, {31'h0, TRANSFER_HALT_FLAG});
    rd(N0, 32'h3);
    INTERRUPT_RETURN_INSTRUCTION <= 1'b1;
    tick(1);
    INTERRUPT_RETURN_INSTRUCTION <= 1'b0;
    quiet();
    chk("resume", 32'd4, starts[0]);
    chk("halt clear", 32'h0, {31'h0, TRANSFER_HALT_FLAG});
    fresh("halt");
    results();
  end
endmodule : tb_dma_request_sync_control
bind dmrs_top dmrs_assertions u_chk (
  .CLK_SYS(CLK_SYS),
  .RST_B(RST_B),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .NMI_EVENT(NMI_EVENT),
  .INTERRUPT_RETURN_INSTRUCTION(INTERRUPT_RETURN_INSTRUCTION),
  .BUS_OWN(BUS_OWN),
  .CYC_START(CYC_START),
  .CYC_FETCH(CYC_FETCH),
  .CYC_DEPOSIT(CYC_DEPOSIT),
  .TRANSFER_HALT_FLAG(TRANSFER_HALT_FLAG)
);
